//--- hdl/scpu_serial_port.sv
// Serial control port with I/O buffers, commit logic and quarter-rate reference.
//
// Behaviour
// - Write bits are taken on rising serial-clock edges and readback bits are driven on falling ones.
// - Serial clock edges count only while chip select is low; with it high the data pins are ignored.
// - The data pin is bidirectional by default and input only when unidirectional mode is set.
// - The readback pin drives only in unidirectional mode and stays quiet otherwise.
// - A high abort input resets the serial state machine and discards buffers written since commit.
// - A high commit pin copies all I/O buffers into the active registers.
// - A configuration bit makes the commit pin an input driven by the host or an output pulsed here.
// - The three tone-set select inputs choose one of eight tone sets.
// - Any change on a tone-set select input commits all I/O buffers like a commit strobe.
// - A reference clock runs at one quarter of the system clock.
// - A high global clear resets the serial port, the buffers and every register to its default.
`timescale 1ns/100ps
module scpu_serial_port #(
  parameter int NUM_REGS = 8,
  parameter int DATA_W = 32
) (
  // System clock, reset and clock enable.
  input wire logic clock,
  input wire logic rst_n,
  input wire logic ce,
  // Serial link.
  input wire logic serial_clock,
  input wire logic cs_n,
  input wire logic sdio_in,
  output logic sdio_out,
  output logic sdio_oe,
  output logic serial_readback_out,
  output logic serial_readback_oe,
  // Port abort and global clear.
  input wire logic io_reset,
  input wire logic master_clear,
  // Commit pin as three signals.
  input wire logic io_update_in,
  output logic io_update_out,
  output logic io_update_oe,
  // Tone-set select and reference clock.
  input wire logic [scpu_pkg::TONE_W-1:0] tone_select_in,
  output logic [scpu_pkg::TONE_W-1:0] tone_select,
  output logic sync_clk,
  // Active registers towards the synthesizer core.
  output logic [NUM_REGS*DATA_W-1:0] active_regs
);
  localparam int AW = (NUM_REGS > 1) ? $clog2(NUM_REGS) : 1;
  localparam int CNT_W = $clog2(scpu_pkg::INSTR_W + DATA_W + 1);
  localparam logic [CNT_W-1:0] IN_END = CNT_W'(scpu_pkg::INSTR_W);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(scpu_pkg::INSTR_W + DATA_W - 1);
  localparam logic [CNT_W-1:0] DONE = CNT_W'(scpu_pkg::INSTR_W + DATA_W);
  localparam logic [scpu_pkg::ADDR_W-1:0] NREG = scpu_pkg::ADDR_W'(NUM_REGS);

  typedef logic [NUM_REGS-1:0][DATA_W-1:0] scpu_bank_t;

  // Receive side on the rising serial clock.
  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic [scpu_pkg::INSTR_W-1:0] instr;
    logic [DATA_W-1:0] shift;
  } scpu_rx_t;

  // Word handed to the system domain; held stable until the next toggle.
  typedef struct packed {
    logic toggle;
    logic [scpu_pkg::ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } scpu_hand_t;

  // Readback side on the falling serial clock.
  typedef struct packed {
    logic loaded;
    logic oe_bi;
    logic oe_uni;
    logic [DATA_W-1:0] word;
  } scpu_tx_t;

  // System clock domain.
  typedef struct packed {
    logic [scpu_pkg::SY_W-1:0] s1;
    logic [scpu_pkg::SY_W-1:0] s2;
    logic [scpu_pkg::DIV_W-1:0] div;
    logic sync_clk;
    logic tog_seen;
    logic auto_pend;
    logic [scpu_pkg::PULSE_W-1:0] pulse;
    logic iou_out;
    logic iou_oe;
    logic [scpu_pkg::TONE_W-1:0] tone;
    scpu_bank_t bufs;
    scpu_bank_t active;
  } scpu_sys_t;

  scpu_rx_t rx_reg, rx_next;
  scpu_hand_t hand_reg, hand_next;
  scpu_tx_t tx_reg, tx_next;
  scpu_sys_t sys_reg, sys_next;
  logic link_rst_n;
  logic sample;
  logic commit;
  logic rd_req;
  logic [scpu_pkg::ADDR_W-1:0] rd_addr;

  // The serial machine restarts whenever chip select rises, abort or clear is high.
  assign link_rst_n = rst_n & ~cs_n & ~io_reset & ~master_clear;

  assign rd_addr = rx_reg.instr[scpu_pkg::ADDR_W-1:0];
  assign rd_req = (rx_reg.cnt == IN_END) && rx_reg.instr[scpu_pkg::RW_BIT];

  always_comb begin
    rx_next = rx_reg;
    hand_next = hand_reg;
    if (rx_reg.cnt < IN_END) begin
      rx_next.instr = {rx_reg.instr[scpu_pkg::INSTR_W-2:0], sdio_in};
    end else if (rx_reg.cnt < DONE) begin
      rx_next.shift = {rx_reg.shift[DATA_W-2:0], sdio_in};
    end
    if (rx_reg.cnt != DONE) begin
      rx_next.cnt = rx_reg.cnt + 1'b1;
    end
    if (rx_reg.cnt == LAST && !rx_reg.instr[scpu_pkg::RW_BIT]) begin
      hand_next.toggle = ~hand_reg.toggle;
      hand_next.addr = rd_addr;
      hand_next.data = {rx_reg.shift[DATA_W-2:0], sdio_in};
    end
  end

  always_ff @(posedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      rx_reg <= '0;
    end else begin
      rx_reg <= rx_next;
    end
  end

  // The handoff word survives chip select so the toggle never flips spuriously.
  always_ff @(posedge serial_clock or negedge rst_n) begin
    if (!rst_n) begin
      hand_reg <= '0;
    end else begin
      hand_reg <= hand_next;
    end
  end

  // Active registers and the mode bit change only at commits and clears, so they are
  // treated as quasi-static here; the word is captured once, so only a commit at the load edge gives mixed data.
  always_comb begin
    tx_next = tx_reg;
    if (rd_req && !tx_reg.loaded) begin
      tx_next.loaded = 1'b1;
      tx_next.oe_uni = sys_reg.active[scpu_pkg::CFG_REG][scpu_pkg::CFG_UNI_BIT];
      tx_next.oe_bi = ~sys_reg.active[scpu_pkg::CFG_REG][scpu_pkg::CFG_UNI_BIT];
      tx_next.word = (rd_addr < NREG) ? sys_reg.active[rd_addr[AW-1:0]] : '0;
    end else if (tx_reg.loaded) begin
      tx_next.word = {tx_reg.word[DATA_W-2:0], 1'b0};
    end
  end

  always_ff @(negedge serial_clock or negedge link_rst_n) begin
    if (!link_rst_n) begin
      tx_reg <= '0;
    end else begin
      tx_reg <= tx_next;
    end
  end

  // System domain: synchronisers, reference divider, buffers and commits.
  always_comb begin
    sys_next = sys_reg;
    commit = 1'b0;
    sys_next.s1 = {hand_reg.toggle, master_clear, io_reset, tone_select_in, io_update_in};
    sys_next.s2 = sys_reg.s1;
    sys_next.div = sys_reg.div + 1'b1;
    sys_next.sync_clk = sys_next.div[scpu_pkg::DIV_W-1];
    sample = (sys_reg.div == scpu_pkg::SYNC_RISE_PHASE);
    sys_next.iou_oe = sys_reg.active[scpu_pkg::CFG_REG][scpu_pkg::CFG_IOU_OUT_BIT];
    if (sys_reg.s2[scpu_pkg::SY_TOG] != sys_reg.tog_seen) begin
      sys_next.tog_seen = sys_reg.s2[scpu_pkg::SY_TOG];
      if (hand_reg.addr < NREG) begin
        sys_next.bufs[hand_reg.addr[AW-1:0]] = hand_reg.data;
      end
      sys_next.auto_pend = sys_reg.iou_oe;
    end
    if (sample) begin
      if (!sys_reg.iou_oe && sys_reg.s2[scpu_pkg::SY_IOU]) begin
        commit = 1'b1;
      end
      if (sys_reg.s2[scpu_pkg::SY_PROF+:scpu_pkg::TONE_W] != sys_reg.tone) begin
        sys_next.tone = sys_reg.s2[scpu_pkg::SY_PROF+:scpu_pkg::TONE_W];
        commit = 1'b1;
      end
    end
    if (sys_reg.auto_pend && sys_reg.iou_oe) begin
      commit = 1'b1;
      sys_next.auto_pend = 1'b0;
      sys_next.pulse = scpu_pkg::IOU_PULSE;
    end else if (sys_reg.pulse != '0) begin
      sys_next.pulse = sys_reg.pulse - 1'b1;
    end
    // Gate with the next mode so a pulse never outlives a switch back to input.
    sys_next.iou_out = (sys_next.pulse != '0) && sys_next.iou_oe;
    if (commit) begin
      sys_next.active = sys_reg.bufs;
    end
    if (sys_reg.s2[scpu_pkg::SY_ABORT]) begin
      sys_next.bufs = sys_reg.active;
      sys_next.auto_pend = 1'b0;
    end
    if (sys_reg.s2[scpu_pkg::SY_CLR]) begin
      sys_next.bufs = {NUM_REGS{scpu_pkg::REG_RESET[DATA_W-1:0]}};
      sys_next.active = {NUM_REGS{scpu_pkg::REG_RESET[DATA_W-1:0]}};
      sys_next.tone = scpu_pkg::TONE_RESET;
      sys_next.auto_pend = 1'b0;
      sys_next.pulse = '0;
      sys_next.iou_out = 1'b0;
      sys_next.iou_oe = 1'b0;
    end
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      sys_reg <= '0;
    end else if (ce) begin
      sys_reg <= sys_next;
    end
  end

  assign sdio_out = tx_reg.word[DATA_W-1];
  assign sdio_oe = tx_reg.oe_bi;
  assign serial_readback_out = tx_reg.word[DATA_W-1];
  assign serial_readback_oe = tx_reg.oe_uni;
  assign io_update_out = sys_reg.iou_out;
  assign io_update_oe = sys_reg.iou_oe;
  assign tone_select = sys_reg.tone;
  assign sync_clk = sys_reg.sync_clk;
  assign active_regs = sys_reg.active;

  sequence s_ref_high;
    sync_clk [*2];
  endsequence

  sequence s_ref_low;
    !sync_clk [*2];
  endsequence

  a_ref_quarter: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    $rose(sync_clk) |-> s_ref_high ##1 s_ref_low)
    else $error("reference clock is not a quarter of the system clock");

  a_commit_copy: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (commit && !sys_reg.s2[scpu_pkg::SY_CLR]) |=> (active_regs == $past(sys_reg.bufs)))
    else $error("commit did not copy the buffers");

  a_tone_commit: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (sample && sys_reg.s2[scpu_pkg::SY_PROF+:scpu_pkg::TONE_W] != tone_select
     && !sys_reg.s2[scpu_pkg::SY_CLR]) |-> commit ##1 (active_regs == $past(sys_reg.bufs)))
    else $error("tone select change did not commit");

  a_tone_follow: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (sample && !sys_reg.s2[scpu_pkg::SY_CLR])
    |=> (tone_select == $past(sys_reg.s2[scpu_pkg::SY_PROF+:scpu_pkg::TONE_W])))
    else $error("tone select not taken at reference edge");

  a_abort_drop: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (sys_reg.s2[scpu_pkg::SY_ABORT] && !sys_reg.s2[scpu_pkg::SY_CLR])
    |=> (sys_reg.bufs == $past(sys_reg.active)))
    else $error("abort did not discard buffers");

  a_clear_all: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    sys_reg.s2[scpu_pkg::SY_CLR] |=> (active_regs == '0) && (tone_select == '0) && !io_update_oe)
    else $error("global clear left state behind");

  a_pin_modes: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
    !(sdio_oe && serial_readback_oe))
    else $error("both readback pins enabled");

  a_cs_quiet: assert property (@(posedge clock) disable iff (!rst_n)
    (cs_n || io_reset) |-> !sdio_oe && !serial_readback_oe)
    else $error("readback drives with chip select high");

  a_read_load: assert property (@(negedge serial_clock) disable iff (!link_rst_n)
    (rd_req && !tx_reg.loaded) |=> (sdio_oe || serial_readback_oe))
    else $error("readback did not start after the instruction byte");

  a_write_hand: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (sys_reg.s2[scpu_pkg::SY_TOG] != sys_reg.tog_seen && hand_reg.addr < NREG
     && !sys_reg.s2[scpu_pkg::SY_ABORT] && !sys_reg.s2[scpu_pkg::SY_CLR])
    |=> (sys_reg.bufs[$past(hand_reg.addr[AW-1:0])] == $past(hand_reg.data)))
    else $error("completed write did not reach its buffer");

  a_tone_hold: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    (!sample && !sys_reg.s2[scpu_pkg::SY_CLR]) |=> (tone_select == $past(tone_select)))
    else $error("tone select moved away from the reference edge");

  a_pulse_len: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    ($rose(io_update_out) && sys_reg.active[scpu_pkg::CFG_REG][scpu_pkg::CFG_IOU_OUT_BIT])
    |-> io_update_out [*4] ##1 !io_update_out)
    else $error("commit pulse is not one reference period long");

  a_iou_dir: assert property (@(posedge clock) disable iff (!rst_n || !ce)
    io_update_out |-> io_update_oe ##0 $past(io_update_oe))
    else $error("commit pin pulsed while an input");
endmodule // scpu_serial_port

//--- hdl/scpu_pkg.sv
// Constants shared by the serial control port and update logic.
package scpu_pkg;
  // Instruction byte layout: read flag on top, register address in the low bits.
  localparam int INSTR_W = 8;
  localparam int RW_BIT = 7;
  localparam int ADDR_W = 5;
  // Tone-set select width, eight stored tone sets.
  localparam int TONE_W = 3;
  localparam logic [TONE_W-1:0] TONE_RESET = 3'h0;
  // Quarter-rate reference: two-bit divider, sample point is the phase before it rises.
  localparam int DIV_W = 2;
  localparam logic [DIV_W-1:0] SYNC_RISE_PHASE = 2'h1;
  // Configuration register index and its bits.
  localparam int CFG_REG = 0;
  localparam int CFG_IOU_OUT_BIT = 0;
  localparam int CFG_UNI_BIT = 1;
  // Commit pulse on the update pin in output mode lasts one reference period.
  localparam int PULSE_W = 3;
  localparam logic [PULSE_W-1:0] IOU_PULSE = 3'h4;
  // Positions inside the pin synchroniser vector.
  localparam int SY_IOU = 0;
  localparam int SY_PROF = 1;
  localparam int SY_ABORT = 4;
  localparam int SY_CLR = 5;
  localparam int SY_TOG = 6;
  localparam int SY_W = 7;
  // Value of every register after reset or global clear.
  localparam logic [31:0] REG_RESET = 32'h0;
endpackage

//--- testbench/scpu_host_model.sv
// Host controller model that drives the serial control port.
`timescale 1ns/100ps
module scpu_host_model (
  // Serial link driven by the host.
  output logic serial_clock,
  output logic cs_n,
  output logic host_sdio,
  // Device side of the data pins.
  input wire logic sdio_out,
  input wire logic sdio_oe,
  input wire logic serial_readback_out,
  input wire logic serial_readback_oe
);
  logic oe_bi_seen;
  logic oe_uni_seen;

  // The link clock rests low between frames.
  initial begin
    serial_clock = 1'b0;
    cs_n = 1'b1;
    host_sdio = 1'b0;
  end

  task automatic xfer(input logic rd, input logic [4:0] addr, input logic [31:0] wdata,
    output logic [31:0] rdata);
    logic [39:0] frame;
    frame = {rd, 2'h0, addr, wdata};
    oe_bi_seen = 1'b0;
    oe_uni_seen = 1'b0;
    #3 cs_n = 1'b0;
    for (int i = 39; i >= 0; i--) begin
      #32 serial_clock = 1'b0;
      // A released data pin toggles so a stale level cannot pass for data.
      host_sdio = (rd && i < 32) ? ~host_sdio : frame[i];
      // An undriven readback line shows the opposite of the host level, never real data.
      #32 rdata[i % 32] = sdio_oe ? sdio_out
        : (serial_readback_oe ? serial_readback_out : ~host_sdio);
      oe_bi_seen |= sdio_oe;
      oe_uni_seen |= serial_readback_oe;
      serial_clock = 1'b1;
    end
    #32 serial_clock = 1'b0;
    #32 cs_n = 1'b1;
    host_sdio = ~host_sdio;
  endtask
endmodule // scpu_host_model

//--- testbench/tb_top.sv
// Self-checking bench for the serial control port and commit logic.
`timescale 1ns/100ps
module tb_top;
  localparam int NR = 8;
  localparam int DW = 32;
  logic clock, rst_n, ce, serial_clock, cs_n, host_sdio, sdio_out, sdio_oe;
  logic serial_readback_out, serial_readback_oe, io_reset, master_clear;
  logic io_update_in, io_update_out, io_update_oe, sync_clk;
  logic [scpu_pkg::TONE_W-1:0] tone_select_in, tone_select;
  logic [NR*DW-1:0] active_regs;
  logic [31:0] d;
  int pulse_n = 0;
  int mismatches = 0;
  int check_count = 0;
  wire sdio_pin = sdio_oe ? sdio_out : host_sdio;

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  always @(posedge clock) pulse_n <= pulse_n + int'(io_update_out === 1'b1);

  scpu_serial_port #(.NUM_REGS(NR), .DATA_W(DW)) scpu_serial_port_inst (
    .clock(clock), .rst_n(rst_n), .ce(ce), .serial_clock(serial_clock), .cs_n(cs_n),
    .sdio_in(sdio_pin), .sdio_out(sdio_out), .sdio_oe(sdio_oe),
    .serial_readback_out(serial_readback_out), .serial_readback_oe(serial_readback_oe),
    .io_reset(io_reset), .master_clear(master_clear), .io_update_in(io_update_in),
    .io_update_out(io_update_out), .io_update_oe(io_update_oe),
    .tone_select_in(tone_select_in), .tone_select(tone_select), .sync_clk(sync_clk),
    .active_regs(active_regs));

  scpu_host_model scpu_host_model_inst (
    .serial_clock(serial_clock), .cs_n(cs_n), .host_sdio(host_sdio), .sdio_out(sdio_out),
    .sdio_oe(sdio_oe), .serial_readback_out(serial_readback_out),
    .serial_readback_oe(serial_readback_oe));

  function automatic logic [31:0] act(input int k);
    return active_regs[k*DW +: DW];
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      $display("ERROR %s expected %h seen %h", nm, exp, got);
      mismatches++;
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clock);
  endtask

  task automatic wr(input logic [4:0] a, input logic [31:0] v);
    scpu_host_model_inst.xfer(1'b0, a, v, d);
    cyc(10);
  endtask

  task automatic commit;
    @(posedge sync_clk);
    @(negedge clock);
    io_update_in = 1'b1;
    cyc(8);
    io_update_in = 1'b0;
    cyc(8);
  endtask

  task automatic t_commit;
    wr(5'h2, 32'ha5c3_0f11);
    chk("held", 32'h0, act(2));
    commit();
    chk("committed", 32'ha5c3_0f11, act(2));
    scpu_host_model_inst.xfer(1'b1, 5'h2, 32'h0, d);
    chk("readback", 32'ha5c3_0f11, d);
    chk("bi oe", 32'h1, scpu_host_model_inst.oe_bi_seen);
    chk("uni oe", 32'h0, scpu_host_model_inst.oe_uni_seen);
    $display("test commit done");
  endtask

  task automatic t_abort;
    wr(5'h3, 32'h1234_5678);
    io_reset = 1'b1;
    cyc(8);
    io_reset = 1'b0;
    cyc(4);
    commit();
    chk("discarded", 32'h0, act(3));
    wr(5'h3, 32'h0bad_f00d);
    commit();
    chk("after abort", 32'h0bad_f00d, act(3));
    $display("test abort done");
  endtask

  task automatic t_tone;
    for (int v = 1; v < 8; v++) begin
      wr(5'h4, 32'(v));
      @(posedge sync_clk);
      @(negedge clock);
      tone_select_in = 3'(v);
      cyc(12);
      chk("tone", 32'(v), 32'(tone_select));
      chk("tone commit", 32'(v), act(4));
    end
    $display("test tone done");
  endtask

  task automatic t_modes;
    int p0;
    wr(5'h0, 32'h2);
    commit();
    scpu_host_model_inst.xfer(1'b1, 5'h4, 32'h0, d);
    chk("uni read", 32'h7, d);
    chk("uni oe", 32'h1, scpu_host_model_inst.oe_uni_seen);
    chk("bi oe", 32'h0, scpu_host_model_inst.oe_bi_seen);
    wr(5'h0, 32'h3);
    commit();
    chk("pin out", 32'h1, 32'(io_update_oe));
    p0 = pulse_n;
    scpu_host_model_inst.xfer(1'b0, 5'h5, 32'h00c0_ffee, d);
    cyc(20);
    chk("pulse len", 32'h4, 32'(pulse_n - p0));
    chk("auto commit", 32'h00c0_ffee, act(5));
    wr(5'h0, 32'h0);
    chk("pin in", 32'h0, 32'(io_update_oe));
    $display("test modes done");
  endtask

  task automatic t_sync;
    int n;
    logic last;
    n = 0;
    last = sync_clk;
    repeat (40) begin
      @(negedge clock);
      if (sync_clk === 1'b1 && last === 1'b0) n++;
      last = sync_clk;
    end
    chk("sync rises", 32'd10, n);
    // With the clock enable low the reference must stand still.
    last = sync_clk;
    ce = 1'b0;
    cyc(8);
    chk("ce freeze", 32'(last), 32'(sync_clk));
    ce = 1'b1;
    $display("test sync done");
  endtask

  task automatic t_clear;
    master_clear = 1'b1;
    cyc(8);
    master_clear = 1'b0;
    cyc(12);
    for (int k = 0; k < NR; k++) chk("cleared", 32'h0, act(k));
    $display("test clear done");
  endtask

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  initial begin
    rst_n = 1'b0;
    ce = 1'b1;
    io_reset = 1'b0;
    master_clear = 1'b0;
    io_update_in = 1'b0;
    tone_select_in = 3'h0;
    cyc(3);
    rst_n = 1'b1;
    cyc(4);
    for (int k = 0; k < NR; k++) chk("reset", 32'h0, act(k));
    t_commit();
    t_abort();
    t_tone();
    t_modes();
    t_sync();
    t_clear();
    wrap_up();
  end

  initial begin
    #150us;
    mismatches++;
    $display("watchdog expired");
    wrap_up();
  end
endmodule // tb_top
